//--- i2c_target_pkg.sv
package i2c_target_pkg;
	// Own address width and I2C mode code on the protocol select field
	localparam int OWN_ADDR_W = 10;
	localparam logic [1:0] PROTO_I2C = 2'h3;
	// First byte prefix of a 10-bit address
	localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
	localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] BIT_CNT_RESET = 4'h0;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	// Sys to link vector: scl, sda, write toggle, read toggle, nack, enable, width, gc, address
	localparam int LK_W = 18;
	localparam int LK_SCL = 0;
	localparam int LK_SDA = 1;
	localparam int LK_WR = 2;
	localparam int LK_RD = 3;
	localparam int LK_NACK = 4;
	localparam int LK_EN = 5;
	localparam int LK_A10 = 6;
	localparam int LK_GC = 7;
	localparam int LK_OA = 8;
	// Link to sys vector: start, stop, tx request, tx load, rx push, direction
	localparam int EV_W = 6;
	localparam int EV_START = 0;
	localparam int EV_STOP = 1;
	localparam int EV_TXREQ = 2;
	localparam int EV_LOAD = 3;
	localparam int EV_PUSH = 4;
	localparam int EV_DIR = 5;
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_ADDR = 9'h002,
		ST_ADDR2 = 9'h004,
		ST_ACK = 9'h008,
		ST_RX = 9'h010,
		ST_RXHOLD = 9'h020,
		ST_TX = 9'h040,
		ST_TXWAIT = 9'h080,
		ST_TXACK = 9'h100
	} link_state_t;
endpackage

//--- i2c_target_engine.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Target when I2C mode, synchronous, not controller
// - Match own address, 7 or 10 bits
// - General call enable gates general call response
// - Address match after START sets start flag
// - Read match transmits; SCL only held low
// - Read: direction, tx request, stretch until loaded
// - Every buffer to shifter load requests again
// - Empty buffer after ack stretches SCL low
// - Transmit NACK then STOP or restart
// - Write match receives, direction cleared
// - Received byte sets ready, auto acknowledge
// - Unread buffer stretches until it is read
// - Force NACK answers next acknowledge cycle
// - Force NACK during stretch overwrites, NACKs
// - Receive STOP sets flag, restart readdresses
// - Full 10-bit address: receive, start flag
// - 10-bit restart read sets direction, flag
// - Controller mode select; multi-master own address
// - 10-bit first byte prefix plus upper bits
module i2c_target_engine (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic link_clk,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_n,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic [1:0] protocol_select,
	input wire logic synchronous_select,
	input wire logic controller_select,
	input wire logic multi_master_enable,
	input wire logic own_address_detect_enable,
	input wire logic [i2c_target_pkg::OWN_ADDR_W-1:0] own_address_register,
	input wire logic own_address_width,
	input wire logic general_call_enable,
	input wire logic force_nack,
	input wire logic [7:0] transmit_buffer,
	input wire logic transmit_buffer_write,
	output logic [7:0] receive_buffer,
	input wire logic receive_buffer_read,
	input wire logic start_flag_clear,
	input wire logic stop_flag_clear,
	output logic direction_bit,
	output logic start_detected_flag,
	output logic stop_detected_flag,
	output logic transmit_request_flag,
	output logic receive_ready_flag,
	output logic transmit_buffer_full,
	output logic target_mode_active,
	output logic controller_mode_active
);
	import i2c_target_pkg::*;

	// Sys domain state
	logic [LK_W-1:LK_NACK] cfg_reg, cfg_next;
	logic wr_tgl_reg, wr_tgl_next, rd_tgl_reg, rd_tgl_next;
	logic [7:0] tx_data_reg, tx_data_next, rx_buf_reg, rx_buf_next;
	logic start_f_reg, start_f_next, stop_f_reg, stop_f_next;
	logic txreq_f_reg, txreq_f_next, rxrdy_f_reg, rxrdy_f_next;
	logic full_reg, full_next, dir_out_reg, dir_out_next;
	logic tgt_reg, tgt_next, ctl_reg, ctl_next;
	logic [EV_W-1:0] ev_s1, ev_s2;
	logic [EV_PUSH:0] ev_s3;
	logic [EV_PUSH:0] ev_edge;
	logic full_now;

	// Link domain state
	logic lrst_s1, link_rst;
	logic [LK_W-1:0] lk_s1, lk_s2;
	logic [LK_RD:0] lk_s3;
	link_state_t state_reg, state_next;
	logic [3:0] bit_reg, bit_next;
	logic [7:0] shift_reg, shift_next, rx_hold_reg, rx_hold_next;
	logic dir_reg, dir_next, addr_reg, addr_next, ten_reg, ten_next;
	logic ack_reg, ack_next, to_tx_reg, to_tx_next, wait_addr_reg, wait_addr_next;
	logic scl_oe_n_reg, scl_oe_n_next, sda_oe_n_reg, sda_oe_n_next;
	logic rx_full_reg, rx_full_next, load_tgl_reg, load_tgl_next;
	logic [EV_PUSH:0] ev_tgl_reg, ev_tgl_next;
	logic scl_rise, scl_fall, start_det, stop_det, tx_avail, rd_edge, fnack;
	logic hit7, hit10, gc_hit, read_hit;
	logic [OWN_ADDR_W-1:0] oa;

	// Sys side: mode decode, buffers and sticky flags
	always_comb begin
		tgt_next = (protocol_select == PROTO_I2C) && synchronous_select && !controller_select;
		ctl_next = (protocol_select == PROTO_I2C) && synchronous_select && controller_select;
		cfg_next = {own_address_register, general_call_enable, own_address_width,
			tgt_reg || (ctl_reg && multi_master_enable && own_address_detect_enable), force_nack};
		ev_edge = ev_s2[EV_PUSH:0] ^ ev_s3;
		full_now = wr_tgl_reg ^ ev_s2[EV_LOAD];
		wr_tgl_next = wr_tgl_reg;
		tx_data_next = tx_data_reg;
		rd_tgl_next = rd_tgl_reg;
		rx_buf_next = rx_buf_reg;
		// Writes while full are dropped so the link never sees a changing word
		if (transmit_buffer_write && !full_now) begin
			wr_tgl_next = !wr_tgl_reg;
			tx_data_next = transmit_buffer;
		end
		full_next = full_now || (transmit_buffer_write && !full_now);
		txreq_f_next = (txreq_f_reg && !(transmit_buffer_write && !full_now))
			|| ev_edge[EV_TXREQ] || ev_edge[EV_LOAD];
		if (receive_buffer_read && rxrdy_f_reg) begin
			rd_tgl_next = !rd_tgl_reg;
		end
		if (ev_edge[EV_PUSH]) begin
			rx_buf_next = rx_hold_reg;
		end
		rxrdy_f_next = (rxrdy_f_reg && !receive_buffer_read) || ev_edge[EV_PUSH];
		start_f_next = (start_f_reg && !start_flag_clear) || ev_edge[EV_START];
		stop_f_next = (stop_f_reg && !stop_flag_clear) || ev_edge[EV_STOP];
		dir_out_next = ev_s2[EV_DIR];
	end

	always_ff @(posedge clock) begin
		ev_s1 <= {dir_reg, ev_tgl_reg};
		ev_s2 <= ev_s1;
		ev_s3 <= ev_s2[EV_PUSH:0];
		if (sys_rst) begin
			cfg_reg <= '0;
			wr_tgl_reg <= 1'b0;
			rd_tgl_reg <= 1'b0;
			tx_data_reg <= BYTE_RESET;
			rx_buf_reg <= BYTE_RESET;
			start_f_reg <= 1'b0;
			stop_f_reg <= 1'b0;
			txreq_f_reg <= 1'b0;
			rxrdy_f_reg <= 1'b0;
			full_reg <= 1'b0;
			dir_out_reg <= 1'b0;
			tgt_reg <= 1'b0;
			ctl_reg <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
			wr_tgl_reg <= wr_tgl_next;
			rd_tgl_reg <= rd_tgl_next;
			tx_data_reg <= tx_data_next;
			rx_buf_reg <= rx_buf_next;
			start_f_reg <= start_f_next;
			stop_f_reg <= stop_f_next;
			txreq_f_reg <= txreq_f_next;
			rxrdy_f_reg <= rxrdy_f_next;
			full_reg <= full_next;
			dir_out_reg <= dir_out_next;
			tgt_reg <= tgt_next;
			ctl_reg <= ctl_next;
		end
	end

	assign receive_buffer = rx_buf_reg;
	assign direction_bit = dir_out_reg;
	assign start_detected_flag = start_f_reg;
	assign stop_detected_flag = stop_f_reg;
	assign transmit_request_flag = txreq_f_reg;
	assign receive_ready_flag = rxrdy_f_reg;
	assign transmit_buffer_full = full_reg;
	assign target_mode_active = tgt_reg;
	assign controller_mode_active = ctl_reg;

	// Link side: reset and pin synchronisers
	always_ff @(posedge link_clk) begin
		lrst_s1 <= sys_rst;
		link_rst <= lrst_s1;
		lk_s1 <= {cfg_reg, rd_tgl_reg, wr_tgl_reg, sda_in, scl_in};
		lk_s2 <= lk_s1;
		lk_s3 <= lk_s2[LK_RD:0];
	end

	always_comb begin
		oa = lk_s2[LK_W-1:LK_OA];
		fnack = lk_s2[LK_NACK];
		scl_rise = lk_s2[LK_SCL] && !lk_s3[LK_SCL];
		scl_fall = !lk_s2[LK_SCL] && lk_s3[LK_SCL];
		start_det = lk_s2[LK_SCL] && lk_s3[LK_SCL] && lk_s3[LK_SDA] && !lk_s2[LK_SDA];
		stop_det = lk_s2[LK_SCL] && lk_s3[LK_SCL] && !lk_s3[LK_SDA] && lk_s2[LK_SDA];
		tx_avail = lk_s2[LK_WR] ^ load_tgl_reg;
		rd_edge = lk_s2[LK_RD] ^ lk_s3[LK_RD];
		hit7 = !lk_s2[LK_A10] && (shift_reg[7:1] == oa[6:0]);
		hit10 = lk_s2[LK_A10] && (shift_reg[7:3] == TEN_BIT_PREFIX)
			&& (shift_reg[2:1] == oa[9:8]);
		gc_hit = lk_s2[LK_GC] && (shift_reg == GENERAL_CALL_ADDR);
		read_hit = shift_reg[0] && (hit7 || (hit10 && ten_reg));
		state_next = state_reg;
		bit_next = bit_reg;
		shift_next = shift_reg;
		rx_hold_next = rx_hold_reg;
		dir_next = dir_reg;
		addr_next = addr_reg;
		ten_next = ten_reg;
		ack_next = ack_reg;
		to_tx_next = to_tx_reg;
		wait_addr_next = wait_addr_reg;
		scl_oe_n_next = scl_oe_n_reg;
		sda_oe_n_next = sda_oe_n_reg;
		load_tgl_next = load_tgl_reg;
		ev_tgl_next = ev_tgl_reg;
		rx_full_next = rx_full_reg && !rd_edge;
		if (!lk_s2[LK_EN]) begin
			state_next = ST_IDLE;
			addr_next = 1'b0;
			ten_next = 1'b0;
			scl_oe_n_next = 1'b1;
			sda_oe_n_next = 1'b1;
		end else if (start_det) begin
			state_next = ST_ADDR;
			bit_next = BIT_CNT_RESET;
			scl_oe_n_next = 1'b1;
			sda_oe_n_next = 1'b1;
		end else if (stop_det) begin
			if (addr_reg) begin
				ev_tgl_next[EV_STOP] = !ev_tgl_reg[EV_STOP];
			end
			state_next = ST_IDLE;
			addr_next = 1'b0;
			ten_next = 1'b0;
			scl_oe_n_next = 1'b1;
			sda_oe_n_next = 1'b1;
		end else begin
			case (state_reg)
				ST_ADDR, ST_ADDR2, ST_RX: begin
					if (scl_rise && bit_reg < BITS_PER_BYTE) begin
						shift_next = {shift_reg[6:0], lk_s2[LK_SDA]};
						bit_next = bit_reg + 4'h1;
					end
					if (scl_fall && bit_reg == BITS_PER_BYTE) begin
						bit_next = BIT_CNT_RESET;
						ack_next = 1'b1;
						to_tx_next = 1'b0;
						state_next = ST_ACK;
						sda_oe_n_next = 1'b0;
						if (state_reg == ST_ADDR && read_hit) begin
							dir_next = 1'b1;
							addr_next = 1'b1;
							ev_tgl_next[EV_START] = !ev_tgl_reg[EV_START];
							ev_tgl_next[EV_TXREQ] = !ev_tgl_reg[EV_TXREQ];
							wait_addr_next = 1'b1;
							state_next = ST_TXWAIT;
							scl_oe_n_next = 1'b0;
							sda_oe_n_next = 1'b1;
						end else if (state_reg == ST_ADDR && hit10 && !shift_reg[0]) begin
							ten_next = 1'b0;
							to_tx_next = 1'b0;
						end else if ((state_reg == ST_ADDR && ((hit7 && !shift_reg[0]) || gc_hit))
							|| (state_reg == ST_ADDR2 && shift_reg == oa[7:0])) begin
							dir_next = 1'b0;
							addr_next = 1'b1;
							ten_next = (state_reg == ST_ADDR2);
							ev_tgl_next[EV_START] = !ev_tgl_reg[EV_START];
						end else if (state_reg == ST_RX) begin
							if (rx_full_reg && !rd_edge && !fnack) begin
								state_next = ST_RXHOLD;
								scl_oe_n_next = 1'b0;
								sda_oe_n_next = 1'b1;
							end else begin
								rx_hold_next = shift_reg;
								rx_full_next = 1'b1;
								ev_tgl_next[EV_PUSH] = !ev_tgl_reg[EV_PUSH];
								ack_next = !fnack;
								sda_oe_n_next = fnack;
							end
						end else begin
							state_next = ST_IDLE;
							sda_oe_n_next = 1'b1;
						end
						if (state_reg == ST_ADDR && hit10 && !shift_reg[0]) begin
							state_next = ST_ACK;
							ack_next = 1'b1;
							sda_oe_n_next = 1'b0;
						end
						if (state_reg == ST_ADDR && hit10 && !shift_reg[0] && !read_hit) begin
							addr_next = addr_reg;
						end
					end
				end
				ST_RXHOLD: begin
					// SDA and SCL move together; the pull-up rise keeps SDA ahead of SCL
					if (!rx_full_reg || rd_edge || fnack) begin
						rx_hold_next = shift_reg;
						rx_full_next = 1'b1;
						ev_tgl_next[EV_PUSH] = !ev_tgl_reg[EV_PUSH];
						ack_next = !fnack;
						sda_oe_n_next = fnack;
						scl_oe_n_next = 1'b1;
						to_tx_next = 1'b0;
						state_next = ST_ACK;
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						sda_oe_n_next = 1'b1;
						bit_next = BIT_CNT_RESET;
						if (!ack_reg) begin
							state_next = ST_IDLE;
						end else if (to_tx_reg) begin
							sda_oe_n_next = shift_reg[7];
							state_next = ST_TX;
						end else if (state_reg == ST_ACK && !addr_reg) begin
							state_next = ST_ADDR2;
						end else begin
							state_next = ST_RX;
						end
					end
				end
				ST_TXWAIT: begin
					if (tx_avail) begin
						shift_next = tx_data_reg;
						load_tgl_next = !load_tgl_reg;
						// Sys side sees the load only through this event bit
						ev_tgl_next[EV_LOAD] = !ev_tgl_reg[EV_LOAD];
						scl_oe_n_next = 1'b1;
						bit_next = BIT_CNT_RESET;
						if (wait_addr_reg) begin
							ack_next = 1'b1;
							to_tx_next = 1'b1;
							sda_oe_n_next = 1'b0;
							state_next = ST_ACK;
						end else begin
							sda_oe_n_next = tx_data_reg[7];
							state_next = ST_TX;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						bit_next = bit_reg + 4'h1;
						if (bit_reg == BITS_PER_BYTE - 4'h1) begin
							sda_oe_n_next = 1'b1;
							state_next = ST_TXACK;
						end else begin
							shift_next = {shift_reg[6:0], 1'b0};
							sda_oe_n_next = shift_reg[6];
						end
					end
				end
				ST_TXACK: begin
					if (scl_rise) begin
						ack_next = !lk_s2[LK_SDA];
					end
					if (scl_fall) begin
						bit_next = BIT_CNT_RESET;
						if (!ack_reg) begin
							state_next = ST_IDLE;
						end else if (tx_avail) begin
							shift_next = tx_data_reg;
							load_tgl_next = !load_tgl_reg;
							ev_tgl_next[EV_LOAD] = !ev_tgl_reg[EV_LOAD];
							sda_oe_n_next = tx_data_reg[7];
							state_next = ST_TX;
						end else begin
							wait_addr_next = 1'b0;
							scl_oe_n_next = 1'b0;
							state_next = ST_TXWAIT;
						end
					end
				end
				default: begin
					state_next = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			state_reg <= ST_IDLE;
			bit_reg <= BIT_CNT_RESET;
			shift_reg <= BYTE_RESET;
			rx_hold_reg <= BYTE_RESET;
			dir_reg <= 1'b0;
			addr_reg <= 1'b0;
			ten_reg <= 1'b0;
			ack_reg <= 1'b0;
			to_tx_reg <= 1'b0;
			wait_addr_reg <= 1'b0;
			scl_oe_n_reg <= 1'b1;
			sda_oe_n_reg <= 1'b1;
			rx_full_reg <= 1'b0;
			load_tgl_reg <= 1'b0;
			ev_tgl_reg <= '0;
		end else begin
			state_reg <= state_next;
			bit_reg <= bit_next;
			shift_reg <= shift_next;
			rx_hold_reg <= rx_hold_next;
			dir_reg <= dir_next;
			addr_reg <= addr_next;
			ten_reg <= ten_next;
			ack_reg <= ack_next;
			to_tx_reg <= to_tx_next;
			wait_addr_reg <= wait_addr_next;
			scl_oe_n_reg <= scl_oe_n_next;
			sda_oe_n_reg <= sda_oe_n_next;
			rx_full_reg <= rx_full_next;
			load_tgl_reg <= load_tgl_next;
			ev_tgl_reg <= ev_tgl_next;
		end
	end

	// Open drain: the value is always low, only the enables move
	always_ff @(posedge link_clk) begin
		scl_out <= 1'b0;
		sda_out <= 1'b0;
	end
	assign scl_oe_n = scl_oe_n_reg;
	assign sda_oe_n = sda_oe_n_reg;

	rx_stretch_a: assert property (@(posedge link_clk) disable iff (link_rst)
		(state_reg == ST_RXHOLD) |-> !scl_oe_n_reg)
		else $error("scl not held while rx buffer full");
	tx_stall_a: assert property (@(posedge link_clk) disable iff (link_rst)
		(state_reg == ST_TXWAIT && !tx_avail && !start_det && !stop_det && lk_s2[LK_EN])
		|=> (state_reg == ST_TXWAIT) && !scl_oe_n_reg)
		else $error("transmit wait released without data");
	ack_drive_a: assert property (@(posedge link_clk) disable iff (link_rst)
		(state_reg == ST_ACK && ack_reg) |-> !sda_oe_n_reg)
		else $error("ack cycle not driving sda low");
	nack_release_a: assert property (@(posedge link_clk) disable iff (link_rst)
		(state_reg == ST_ACK && !ack_reg) |-> sda_oe_n_reg)
		else $error("nack cycle drives sda");
	restart_addr_a: assert property (@(posedge link_clk) disable iff (link_rst)
		(start_det && lk_s2[LK_EN]) |=> (state_reg == ST_ADDR) && (bit_reg == BIT_CNT_RESET))
		else $error("restart did not return to address reception");
	stop_event_a: assert property (@(posedge link_clk) disable iff (link_rst)
		(stop_det && lk_s2[LK_EN] && !start_det && addr_reg)
		|=> ev_tgl_reg[EV_STOP] != $past(ev_tgl_reg[EV_STOP]))
		else $error("stop while addressed not signalled");
	read_dir_a: assert property (@(posedge link_clk) disable iff (link_rst)
		(state_reg == ST_ADDR && scl_fall && bit_reg == BITS_PER_BYTE && read_hit
		&& lk_s2[LK_EN] && !start_det && !stop_det)
		|=> dir_reg && (state_reg == ST_TXWAIT) && !scl_oe_n_reg)
		else $error("read match did not set direction and stretch");
	start_flag_a: assert property (@(posedge clock) disable iff (sys_rst)
		ev_edge[EV_START] |=> start_detected_flag)
		else $error("start event lost");
	tx_req_a: assert property (@(posedge clock) disable iff (sys_rst)
		ev_edge[EV_LOAD] |=> transmit_request_flag)
		else $error("buffer load did not request data");
	rx_ready_a: assert property (@(posedge clock) disable iff (sys_rst)
		ev_edge[EV_PUSH] |=> receive_ready_flag && (receive_buffer == $past(rx_hold_reg)))
		else $error("received byte not presented");
endmodule // i2c_target_engine

//--- i2c_ctl_model.sv
`timescale 1ns/1ns
module i2c_ctl_model (
	input wire logic scl_line,
	input wire logic sda_line,
	output logic scl_low,
	output logic sda_low,
	output logic hang
);
	localparam int QTR = 400;
	localparam int HALF = 800;
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
		hang = 1'b0;
	end
	// Released lines rise through the pull-ups; honour target stretching
	task automatic scl_up();
		int i;
		scl_low = 1'b0;
		for (i = 0; i < 5000 && scl_line !== 1'b1; i++) #10;
		if (scl_line !== 1'b1) hang = 1'b1;
	endtask
	task automatic bit_out(input logic b);
		sda_low = ~b;
		#QTR;
		scl_up();
		#HALF;
		scl_low = 1'b1;
		#QTR;
	endtask
	task automatic bit_in(output logic b);
		sda_low = 1'b0;
		#QTR;
		scl_up();
		#(HALF/2);
		b = sda_line;
		#(HALF/2);
		scl_low = 1'b1;
		#QTR;
	endtask
	// Serves as first START and as repeated START
	task automatic send_start();
		sda_low = 1'b0;
		#QTR;
		scl_up();
		#HALF;
		sda_low = 1'b1;
		#HALF;
		scl_low = 1'b1;
		#QTR;
	endtask
	task automatic send_stop();
		sda_low = 1'b1;
		#QTR;
		scl_up();
		#HALF;
		sda_low = 1'b0;
		#HALF;
	endtask
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic n;
		for (int k = 7; k >= 0; k--) bit_out(d[k]);
		bit_in(n);
		ack = ~n;
	endtask
	task automatic rd_byte(output logic [7:0] d, input logic ack);
		for (int k = 7; k >= 0; k--) bit_in(d[k]);
		bit_out(~ack);
	endtask
endmodule // i2c_ctl_model

//--- tb_top.sv
`timescale 1ns/1ns
module tb_top;
	import i2c_target_pkg::*;
	logic clock, sys_rst, link_clk, scl_out, scl_oe_n, sda_out, sda_oe_n;
	logic [1:0] protocol_select;
	logic synchronous_select, controller_select, multi_master_enable, own_address_detect_enable;
	logic [OWN_ADDR_W-1:0] own_address_register;
	logic own_address_width, general_call_enable, force_nack, transmit_buffer_write;
	logic receive_buffer_read, start_flag_clear, stop_flag_clear, direction_bit;
	logic [7:0] transmit_buffer, receive_buffer, d;
	logic start_detected_flag, stop_detected_flag, transmit_request_flag, receive_ready_flag;
	logic transmit_buffer_full, target_mode_active, controller_mode_active;
	logic ctl_scl_low, ctl_sda_low, hang, ack;
	int bad_count, cmp_count;
	wire scl_line;
	wire sda_line;
	// Wire-AND of both parties over the pull-ups
	assign scl_line = ~(ctl_scl_low | ~scl_oe_n);
	assign sda_line = ~(ctl_sda_low | ~sda_oe_n);
	i2c_target_engine i2c_target_engine_inst (.clock(clock), .sys_rst(sys_rst),
		.link_clk(link_clk), .scl_in(scl_line), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.protocol_select(protocol_select), .synchronous_select(synchronous_select),
		.controller_select(controller_select), .multi_master_enable(multi_master_enable),
		.own_address_detect_enable(own_address_detect_enable),
		.own_address_register(own_address_register), .own_address_width(own_address_width),
		.general_call_enable(general_call_enable), .force_nack(force_nack),
		.transmit_buffer(transmit_buffer), .transmit_buffer_write(transmit_buffer_write),
		.receive_buffer(receive_buffer), .receive_buffer_read(receive_buffer_read),
		.start_flag_clear(start_flag_clear), .stop_flag_clear(stop_flag_clear),
		.direction_bit(direction_bit), .start_detected_flag(start_detected_flag),
		.stop_detected_flag(stop_detected_flag), .transmit_request_flag(transmit_request_flag),
		.receive_ready_flag(receive_ready_flag), .transmit_buffer_full(transmit_buffer_full),
		.target_mode_active(target_mode_active), .controller_mode_active(controller_mode_active));
	i2c_ctl_model i2c_ctl_model_inst (.scl_line(scl_line), .sda_line(sda_line),
		.scl_low(ctl_scl_low), .sda_low(ctl_sda_low), .hang(hang));
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial begin
		link_clk = 1'b0;
		#7;
		forever #15 link_clk = ~link_clk;
	end
	task automatic complete_run();
		$display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge hang) begin
		bad_count++;
		complete_run();
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic checkb(input logic seen, input logic exp);
		check({7'h00, seen}, {7'h00, exp});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask
	function automatic logic pick(input int sel);
		case (sel)
			0: return start_detected_flag;
			1: return receive_ready_flag;
			2: return ~transmit_buffer_full;
			default: return ~scl_oe_n;
		endcase
	endfunction
	task automatic wait_on(input int sel);
		int i;
		for (i = 0; i < 3000 && pick(sel) !== 1'b1; i++) tick(1);
		if (i == 3000) begin
			bad_count++;
			complete_run();
		end
	endtask
	task automatic pulse_wr(input logic [7:0] v);
		transmit_buffer = v;
		transmit_buffer_write = 1'b1;
		tick(1);
		transmit_buffer_write = 1'b0;
	endtask
	task automatic pulse_rd();
		tick(1);
		receive_buffer_read = 1'b1;
		tick(1);
		receive_buffer_read = 1'b0;
	endtask
	task automatic clr_flags();
		tick(1);
		start_flag_clear = 1'b1;
		stop_flag_clear = 1'b1;
		tick(1);
		start_flag_clear = 1'b0;
		stop_flag_clear = 1'b0;
	endtask
	task automatic test_modes();
		logic [3:0] cfg [4] = '{4'hE, 4'hA, 4'hC, 4'hF};
		foreach (cfg[k]) begin
			{protocol_select, synchronous_select, controller_select} = cfg[k];
			multi_master_enable = cfg[k][0];
			own_address_detect_enable = cfg[k][0];
			tick(3);
			checkb(target_mode_active, cfg[k] == 4'hE);
			checkb(controller_mode_active, cfg[k] == 4'hF);
		end
		{protocol_select, synchronous_select, controller_select} = 4'hE;
		multi_master_enable = 1'b0;
		own_address_detect_enable = 1'b0;
		tick(3);
		$display("Mode decode test done");
	endtask
	task automatic test_addr();
		clr_flags();
		i2c_ctl_model_inst.send_start();
		i2c_ctl_model_inst.wr_byte({own_address_register[6:0] ^ 7'h01, 1'b0}, ack);
		checkb(ack, 1'b0);
		i2c_ctl_model_inst.send_stop();
		checkb(start_detected_flag, 1'b0);
		for (int g = 1; g >= 0; g--) begin
			tick(1);
			general_call_enable = g[0];
			i2c_ctl_model_inst.send_start();
			i2c_ctl_model_inst.wr_byte(GENERAL_CALL_ADDR, ack);
			checkb(ack, g[0]);
			if (g == 1) begin
				i2c_ctl_model_inst.wr_byte(8'h81, ack);
				wait_on(1);
				check(receive_buffer, 8'h81);
				checkb(direction_bit, 1'b0);
				pulse_rd();
			end
			i2c_ctl_model_inst.send_stop();
		end
		$display("Address match test done");
	endtask
	task automatic test_write();
		clr_flags();
		i2c_ctl_model_inst.send_start();
		i2c_ctl_model_inst.wr_byte({own_address_register[6:0], 1'b0}, ack);
		checkb(ack, 1'b1);
		tick(4);
		checkb(start_detected_flag, 1'b1);
		checkb(direction_bit, 1'b0);
		i2c_ctl_model_inst.wr_byte(8'hA5, ack);
		checkb(ack, 1'b1);
		wait_on(1);
		check(receive_buffer, 8'hA5);
		// First byte left unread so the next one must stall
		fork
			i2c_ctl_model_inst.wr_byte(8'h3C, ack);
			begin
				wait_on(3);
				check(receive_buffer, 8'hA5);
				pulse_rd();
			end
		join
		checkb(ack, 1'b1);
		wait_on(1);
		check(receive_buffer, 8'h3C);
		fork
			i2c_ctl_model_inst.wr_byte(8'hC3, ack);
			begin
				wait_on(3);
				force_nack = 1'b1;
			end
		join
		checkb(ack, 1'b0);
		tick(4);
		check(receive_buffer, 8'hC3);
		force_nack = 1'b0;
		i2c_ctl_model_inst.send_stop();
		tick(4);
		checkb(stop_detected_flag, 1'b1);
		pulse_rd();
		$display("Receive test done");
	endtask
	task automatic test_force();
		i2c_ctl_model_inst.send_start();
		i2c_ctl_model_inst.wr_byte({own_address_register[6:0], 1'b0}, ack);
		tick(1);
		force_nack = 1'b1;
		i2c_ctl_model_inst.wr_byte(8'h5A, ack);
		checkb(ack, 1'b0);
		tick(1);
		force_nack = 1'b0;
		i2c_ctl_model_inst.send_stop();
		pulse_rd();
		$display("Forced NACK test done");
	endtask
	task automatic test_read();
		clr_flags();
		checkb(scl_out, 1'b0);
		checkb(sda_out, 1'b0);
		i2c_ctl_model_inst.send_start();
		fork
			i2c_ctl_model_inst.wr_byte({own_address_register[6:0], 1'b1}, ack);
			begin
				wait_on(0);
				tick(4);
				checkb(transmit_request_flag, 1'b1);
				checkb(direction_bit, 1'b1);
				checkb(scl_oe_n, 1'b0);
				pulse_wr(8'h96);
				checkb(transmit_buffer_full, 1'b1);
			end
		join
		checkb(ack, 1'b1);
		wait_on(2);
		checkb(transmit_request_flag, 1'b1);
		i2c_ctl_model_inst.rd_byte(d, 1'b1);
		check(d, 8'h96);
		fork
			i2c_ctl_model_inst.rd_byte(d, 1'b0);
			begin
				wait_on(3);
				pulse_wr(8'h4B);
			end
		join
		check(d, 8'h4B);
		i2c_ctl_model_inst.send_start();
		i2c_ctl_model_inst.wr_byte({own_address_register[6:0], 1'b0}, ack);
		checkb(ack, 1'b1);
		tick(4);
		checkb(direction_bit, 1'b0);
		i2c_ctl_model_inst.send_stop();
		tick(4);
		checkb(stop_detected_flag, 1'b1);
		$display("Transmit test done");
	endtask
	task automatic test_ten();
		own_address_width = 1'b1;
		own_address_register = 10'h2A5;
		clr_flags();
		i2c_ctl_model_inst.send_start();
		i2c_ctl_model_inst.wr_byte({TEN_BIT_PREFIX, own_address_register[9:8], 1'b0}, ack);
		checkb(ack, 1'b1);
		i2c_ctl_model_inst.wr_byte(own_address_register[7:0], ack);
		checkb(ack, 1'b1);
		tick(4);
		checkb(start_detected_flag, 1'b1);
		checkb(direction_bit, 1'b0);
		i2c_ctl_model_inst.wr_byte(8'h69, ack);
		wait_on(1);
		check(receive_buffer, 8'h69);
		pulse_rd();
		clr_flags();
		i2c_ctl_model_inst.send_start();
		fork
			i2c_ctl_model_inst.wr_byte({TEN_BIT_PREFIX, own_address_register[9:8], 1'b1}, ack);
			begin
				wait_on(0);
				tick(4);
				checkb(direction_bit, 1'b1);
				pulse_wr(8'hE1);
			end
		join
		i2c_ctl_model_inst.rd_byte(d, 1'b0);
		check(d, 8'hE1);
		i2c_ctl_model_inst.send_stop();
		tick(4);
		checkb(stop_detected_flag, 1'b1);
		own_address_width = 1'b0;
		own_address_register = 10'h012;
		$display("Ten bit test done");
	endtask
	initial begin
		bad_count = 0;
		cmp_count = 0;
		{protocol_select, synchronous_select, controller_select} = 4'hE;
		{multi_master_enable, own_address_detect_enable, own_address_width} = 3'h0;
		{general_call_enable, force_nack, transmit_buffer_write} = 3'h0;
		{receive_buffer_read, start_flag_clear, stop_flag_clear} = 3'h0;
		own_address_register = 10'h012;
		transmit_buffer = 8'h00;
		sys_rst = 1'b1;
		tick(16);
		check({scl_oe_n, sda_oe_n, direction_bit, start_detected_flag, receive_ready_flag,
			transmit_request_flag, stop_detected_flag, transmit_buffer_full}, 8'hC0);
		sys_rst = 1'b0;
		tick(10);
		test_modes();
		test_addr();
		test_write();
		test_force();
		test_read();
		test_ten();
		complete_run();
	end
endmodule // tb_top
